/* File: rtl/vsel_map.vh */
// Register map, field positions, reset values and timing counts
`ifndef VSEL_MAP_VH
`define VSEL_MAP_VH
`define ADDR_MCU_CONTROL 8'h55
`define ADDR_SENSE_LOW 8'h69
`define ADDR_SENSE_HIGH 8'h6A
`define ADDR_PC_ENABLE 8'h68
`define ADDR_PC_MASK_ZERO 8'h6B
`define ADDR_PC_MASK_ONE 8'h6C
`define ADDR_PC_MASK_TWO 8'h6D
`define ADDR_EXT_MASK 8'h3D
`define ADDR_EXT_FLAGS 8'h3C
`define ADDR_PC_FLAGS 8'h3B
`define ADDR_STATUS 8'h3A
`define BIT_UNLOCK 0
`define BIT_VSEL 1
`define BIT_PUD 4
`define BIT_JTD 7
`define MCU_CONTROL_WMASK 8'h90
`define RST_BYTE 8'h00
`define UNLOCK_CYCLES 3'h4
`define VEC_APP_BASE 17'h00000
`define VEC_APP_FIRST 17'h00002
`define VEC_BOOT_8K 17'h1F000
`define VEC_BOOT_4K 17'h1F800
`define VEC_BOOT_2K 17'h1FC00
`define VEC_BOOT_1K 17'h1FE00
`define VEC_LAST_OFFSET 17'h00070
`endif

/* File: rtl/ext_sense.v */
// Sense logic for one dedicated external interrupt pin
`timescale 1ns/1ps
module ext_sense (
    input wire clk_i,
    input wire arst_n_i,
    input wire pin_i,
    input wire pin_async_i,
    input wire async_edge_i,
    input wire io_clk_run_i,
    input wire [1:0] mode_i,
    input wire clr_i,
    output wire level_o,
    output reg flag_o
);
    reg prev_r;
    wire rise;
    wire fall;
    wire hit;
    assign level_o = (mode_i == 2'b00) & ~pin_async_i;
    assign rise = pin_i & ~prev_r;
    assign fall = ~pin_i & prev_r;
    assign hit = io_clk_run_i | async_edge_i;
    always @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            prev_r <= 1'b1;
            flag_o <= 1'b0;
        end else begin
            if (hit) begin
                prev_r <= pin_i;
            end
            if (mode_i == 2'b00) begin
                flag_o <= 1'b0;
            end else if (hit && ((mode_i == 2'b01 && (rise || fall)) ||
                    (mode_i == 2'b10 && fall) ||
                    (mode_i == 2'b11 && rise))) begin
                flag_o <= 1'b1;
            end else if (clr_i) begin
                flag_o <= 1'b0;
            end
        end
    end
endmodule

/* File: rtl/vector_select_ext_irq.v */
// Vector placement control and external interrupt detection
`timescale 1ns/1ps
`include "vsel_map.vh"
module vector_select_ext_irq (
    input wire MCLK_I,
    input wire ARST_N_I,
    input wire [7:0] ADDR_I,
    input wire [7:0] WDATA_I,
    input wire WR_I,
    input wire RD_I,
    output reg [7:0] RDATA_O,
    input wire [7:0] DED_IRQ_PINS_I,
    input wire [23:0] PIN_CHANGE_INPUTS_I,
    input wire [1:0] BOOT_SIZE_FUSE_I,
    input wire RESET_TO_BOOT_FUSE_I,
    input wire APP_SIDE_LOCK_BIT_I,
    input wire BOOT_SIDE_LOCK_BIT_I,
    input wire EXEC_IN_BOOT_I,
    input wire INSTR_DONE_I,
    input wire SLEEP_I,
    input wire SLEEP_IDLE_I,
    input wire STARTUP_DONE_I,
    input wire [10:0] IRQ_ACK_I,
    output reg [16:0] VECTOR_BASE_O,
    output reg [16:0] RESET_VECTOR_O,
    output reg [16:0] FIRST_VECTOR_O,
    output reg [16:0] LAST_VECTOR_O,
    output reg IRQ_BLOCK_O,
    output reg [10:0] IRQ_REQ_O,
    output reg WAKE_O,
    output reg IO_CLK_RUN_O,
    output reg PULLUP_DISABLE_O,
    output reg DEBUG_PORT_DISABLE_O
);
    localparam ST_IDLE = 3'b001;
    localparam ST_OPEN = 3'b010;
    localparam ST_HOLD = 3'b100;

    ////////////////////////////////////////////////////////////////////
    // Pin synchronisers: three stages, a change counts when 2 and 3 agree
    reg [7:0] ded_s1_r, ded_s2_r, ded_s3_r, ded_v_r;
    reg [23:0] pc_s1_r, pc_s2_r, pc_s3_r, pc_v_r;
    always @(posedge MCLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            ded_s1_r <= 8'hFF;
            ded_s2_r <= 8'hFF;
            ded_s3_r <= 8'hFF;
            ded_v_r <= 8'hFF;
            pc_s1_r <= 24'h000000;
            pc_s2_r <= 24'h000000;
            pc_s3_r <= 24'h000000;
            pc_v_r <= 24'h000000;
        end else begin
            ded_s1_r <= DED_IRQ_PINS_I;
            ded_s2_r <= ded_s1_r;
            ded_s3_r <= ded_s2_r;
            ded_v_r <= (ded_s2_r & ded_s3_r) | (ded_v_r & (ded_s2_r | ded_s3_r));
            pc_s1_r <= PIN_CHANGE_INPUTS_I;
            pc_s2_r <= pc_s1_r;
            pc_s3_r <= pc_s2_r;
            pc_v_r <= (pc_s2_r & pc_s3_r) | (pc_v_r & (pc_s2_r | pc_s3_r));
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Registers
    reg [7:0] mcu_control_r;
    reg [7:0] sense_low_r, sense_high_r, ext_mask_r;
    reg [2:0] pc_enable_r, pc_flags_r;
    reg [7:0] pc_mask_r [0:2];
    reg [2:0] state_r, state_nxt;
    reg [2:0] cnt_r, cnt_nxt;
    reg vsel_nxt, unlock_nxt;
    wire wr_mcu = WR_I && (ADDR_I == `ADDR_MCU_CONTROL);
    wire wr_flags = WR_I && (ADDR_I == `ADDR_EXT_FLAGS);
    wire wr_pcf = WR_I && (ADDR_I == `ADDR_PC_FLAGS);
    wire io_run = ~SLEEP_I | SLEEP_IDLE_I;

    ////////////////////////////////////////////////////////////////////
    // Vector change sequence
    always @* begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        vsel_nxt = mcu_control_r[`BIT_VSEL];
        unlock_nxt = mcu_control_r[`BIT_UNLOCK];
        case (state_r)
            ST_IDLE: begin
                if (wr_mcu && WDATA_I[`BIT_UNLOCK]) begin
                    state_nxt = ST_OPEN;
                    cnt_nxt = `UNLOCK_CYCLES;
                    unlock_nxt = 1'b1;
                end
            end
            ST_OPEN: begin
                cnt_nxt = cnt_r - 3'h1;
                if (wr_mcu && !WDATA_I[`BIT_UNLOCK]) begin
                    vsel_nxt = WDATA_I[`BIT_VSEL];
                    unlock_nxt = 1'b0;
                    state_nxt = ST_HOLD;
                end else if (cnt_r == 3'h1) begin
                    unlock_nxt = 1'b0;
                    state_nxt = ST_IDLE;
                end
            end
            ST_HOLD: begin
                if (INSTR_DONE_I) begin
                    state_nxt = ST_IDLE;
                end
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // Dedicated pins
    wire [15:0] sense_all = {sense_high_r, sense_low_r};
    wire [7:0] ded_flag, ded_level;
    genvar g;
    generate
        for (g = 0; g < 8; g = g + 1) begin : g_ded
            ext_sense u_sense (
                .clk_i(MCLK_I),
                .arst_n_i(ARST_N_I),
                .pin_i(ded_v_r[g]),
                .pin_async_i(ded_s2_r[g]),
                .async_edge_i(g < 4),
                .io_clk_run_i(io_run),
                .mode_i(sense_all[2*g+1:2*g]),
                .clr_i((wr_flags && WDATA_I[g]) || IRQ_ACK_I[g]),
                .level_o(ded_level[g]),
                .flag_o(ded_flag[g])
            );
        end
    endgenerate

    // Pin change toggles per group
    wire [23:0] pc_mask_all = {pc_mask_r[2], pc_mask_r[1], pc_mask_r[0]};
    reg [23:0] pc_prev_r;
    wire [23:0] pc_tog = (pc_v_r ^ pc_prev_r) & pc_mask_all;
    wire [2:0] pc_hit = {|pc_tog[23:16], |pc_tog[15:8], |pc_tog[7:0]};

    reg [16:0] boot_base;
    always @* begin
        if (BOOT_SIZE_FUSE_I == 2'b00) begin
            boot_base = `VEC_BOOT_8K;
        end else if (BOOT_SIZE_FUSE_I == 2'b01) begin
            boot_base = `VEC_BOOT_4K;
        end else if (BOOT_SIZE_FUSE_I == 2'b10) begin
            boot_base = `VEC_BOOT_2K;
        end else begin
            boot_base = `VEC_BOOT_1K;
        end
    end
    wire vsel = mcu_control_r[`BIT_VSEL];
    wire lock_block = (vsel && APP_SIDE_LOCK_BIT_I && !EXEC_IN_BOOT_I) ||
        (!vsel && BOOT_SIDE_LOCK_BIT_I && EXEC_IN_BOOT_I);
    wire [7:0] ded_req = ext_mask_r & (ded_flag | ded_level);
    wire [2:0] pc_req = pc_enable_r & pc_flags_r;
    // Level requests on IRQ_REQ_O stay gated until start-up completes; WAKE_O is not gated
    wire [7:0] lvl_gate = STARTUP_DONE_I ? 8'hFF : ~ded_level;

    ////////////////////////////////////////////////////////////////////
    // State and register updates
    integer i;
    always @(posedge MCLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            state_r <= ST_IDLE;
            cnt_r <= 3'h0;
            mcu_control_r <= `RST_BYTE;
            sense_low_r <= `RST_BYTE;
            sense_high_r <= `RST_BYTE;
            ext_mask_r <= `RST_BYTE;
            pc_enable_r <= 3'h0;
            pc_flags_r <= 3'h0;
            pc_prev_r <= 24'h000000;
            for (i = 0; i < 3; i = i + 1) begin
                pc_mask_r[i] <= `RST_BYTE;
            end
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            mcu_control_r[`BIT_VSEL] <= vsel_nxt;
            mcu_control_r[`BIT_UNLOCK] <= unlock_nxt;
            if (wr_mcu) begin
                mcu_control_r[`BIT_PUD] <= WDATA_I[`BIT_PUD];
                mcu_control_r[`BIT_JTD] <= WDATA_I[`BIT_JTD];
            end
            pc_prev_r <= pc_v_r;
            for (i = 0; i < 3; i = i + 1) begin
                if (pc_hit[i]) begin
                    pc_flags_r[i] <= 1'b1;
                end else if ((wr_pcf && WDATA_I[i]) || IRQ_ACK_I[8+i]) begin
                    pc_flags_r[i] <= 1'b0;
                end
            end
            if (WR_I) begin
                if (ADDR_I == `ADDR_SENSE_LOW) begin
                    sense_low_r <= WDATA_I;
                end else if (ADDR_I == `ADDR_SENSE_HIGH) begin
                    sense_high_r <= WDATA_I;
                end else if (ADDR_I == `ADDR_EXT_MASK) begin
                    ext_mask_r <= WDATA_I;
                end else if (ADDR_I == `ADDR_PC_ENABLE) begin
                    pc_enable_r <= WDATA_I[2:0];
                end else if (ADDR_I == `ADDR_PC_MASK_ZERO) begin
                    pc_mask_r[0] <= WDATA_I;
                end else if (ADDR_I == `ADDR_PC_MASK_ONE) begin
                    pc_mask_r[1] <= WDATA_I;
                end else if (ADDR_I == `ADDR_PC_MASK_TWO) begin
                    pc_mask_r[2] <= WDATA_I;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Outputs
    always @(posedge MCLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            RDATA_O <= 8'h00;
            VECTOR_BASE_O <= `VEC_APP_BASE;
            RESET_VECTOR_O <= `VEC_APP_BASE;
            FIRST_VECTOR_O <= `VEC_APP_FIRST;
            LAST_VECTOR_O <= `VEC_LAST_OFFSET;
            IRQ_BLOCK_O <= 1'b0;
            IRQ_REQ_O <= 11'h000;
            WAKE_O <= 1'b0;
            IO_CLK_RUN_O <= 1'b1;
            PULLUP_DISABLE_O <= 1'b0;
            DEBUG_PORT_DISABLE_O <= 1'b0;
        end else begin
            RDATA_O <= 8'h00;
            if (RD_I) begin
                if (ADDR_I == `ADDR_MCU_CONTROL) begin
                    RDATA_O <= mcu_control_r;
                end else if (ADDR_I == `ADDR_SENSE_LOW) begin
                    RDATA_O <= sense_low_r;
                end else if (ADDR_I == `ADDR_SENSE_HIGH) begin
                    RDATA_O <= sense_high_r;
                end else if (ADDR_I == `ADDR_EXT_MASK) begin
                    RDATA_O <= ext_mask_r;
                end else if (ADDR_I == `ADDR_EXT_FLAGS) begin
                    RDATA_O <= ded_flag;
                end else if (ADDR_I == `ADDR_PC_ENABLE) begin
                    RDATA_O <= {5'h00, pc_enable_r};
                end else if (ADDR_I == `ADDR_PC_FLAGS) begin
                    RDATA_O <= {5'h00, pc_flags_r};
                end else if (ADDR_I == `ADDR_PC_MASK_ZERO) begin
                    RDATA_O <= pc_mask_r[0];
                end else if (ADDR_I == `ADDR_PC_MASK_ONE) begin
                    RDATA_O <= pc_mask_r[1];
                end else if (ADDR_I == `ADDR_PC_MASK_TWO) begin
                    RDATA_O <= pc_mask_r[2];
                end else if (ADDR_I == `ADDR_STATUS) begin
                    RDATA_O <= {5'h00, state_r};
                end
            end
            VECTOR_BASE_O <= vsel ? boot_base : `VEC_APP_BASE;
            RESET_VECTOR_O <= RESET_TO_BOOT_FUSE_I ? boot_base
                : `VEC_APP_BASE;
            FIRST_VECTOR_O <= vsel ? boot_base + `VEC_APP_FIRST
                : `VEC_APP_FIRST;
            LAST_VECTOR_O <= (vsel ? boot_base : `VEC_APP_BASE)
                + `VEC_LAST_OFFSET;
            // Global enable flag lives in the core and is never touched
            IRQ_BLOCK_O <= (state_nxt != ST_IDLE) || lock_block;
            IRQ_REQ_O <= {pc_req, ded_req & lvl_gate};
            WAKE_O <= SLEEP_I && ((|(ext_mask_r[3:0] & ded_flag[3:0])) ||
                (|(ext_mask_r & ded_level)) || (|pc_req));
            IO_CLK_RUN_O <= io_run;
            PULLUP_DISABLE_O <= mcu_control_r[`BIT_PUD];
            DEBUG_PORT_DISABLE_O <= mcu_control_r[`BIT_JTD];
        end
    end
endmodule

/* File: verif/vector_select_ext_irq_checker.sv */
// Port-level assertions for vector placement and interrupt blocking
`timescale 1ns/1ps
`include "vsel_map.vh"
module vector_select_ext_irq_checker (
    input wire MCLK_I,
    input wire ARST_N_I,
    input wire [7:0] ADDR_I,
    input wire [7:0] WDATA_I,
    input wire WR_I,
    input wire RD_I,
    input wire [7:0] RDATA_O,
    input wire [1:0] BOOT_SIZE_FUSE_I,
    input wire RESET_TO_BOOT_FUSE_I,
    input wire APP_SIDE_LOCK_BIT_I,
    input wire BOOT_SIDE_LOCK_BIT_I,
    input wire EXEC_IN_BOOT_I,
    input wire SLEEP_I,
    input wire SLEEP_IDLE_I,
    input wire [16:0] VECTOR_BASE_O,
    input wire [16:0] RESET_VECTOR_O,
    input wire [16:0] LAST_VECTOR_O,
    input wire IRQ_BLOCK_O,
    input wire IO_CLK_RUN_O
);
    wire mcu_wr = WR_I && ADDR_I == `ADDR_MCU_CONTROL;
    wire no_lock = !APP_SIDE_LOCK_BIT_I && !BOOT_SIDE_LOCK_BIT_I;
    wire [16:0] boot_base = BOOT_SIZE_FUSE_I == 2'h0 ? `VEC_BOOT_8K :
        BOOT_SIZE_FUSE_I == 2'h1 ? `VEC_BOOT_4K :
        BOOT_SIZE_FUSE_I == 2'h2 ? `VEC_BOOT_2K : `VEC_BOOT_1K;
    default clocking @(posedge MCLK_I); endclocking
    default disable iff (!ARST_N_I);
    a_unlock_blocks: assert property (
        mcu_wr && WDATA_I[0] |=> IRQ_BLOCK_O)
        else $error("block missing after unlock write");
    a_unlock_timeout: assert property (
        mcu_wr && WDATA_I[0] && no_lock ##1 !WR_I [*4] |=> !IRQ_BLOCK_O)
        else $error("block outlived unlock window");
    a_vsel_to_boot: assert property (
        mcu_wr && WDATA_I[1:0] == 2'h1 ##[1:4]
        mcu_wr && WDATA_I[1:0] == 2'h2 |-> ##2 VECTOR_BASE_O == boot_base)
        else $error("vector base not moved to boot area");
    a_vsel_to_app: assert property (
        mcu_wr && WDATA_I[1:0] == 2'h1 ##[1:4]
        mcu_wr && WDATA_I[1:0] == 2'h0 |-> ##2 VECTOR_BASE_O == 17'h00000)
        else $error("vector base not moved to flash start");
    a_table_span: assert property (
        LAST_VECTOR_O == VECTOR_BASE_O + `VEC_LAST_OFFSET)
        else $error("last vector not at table end");
    a_reset_vec: assert property (
        RESET_TO_BOOT_FUSE_I && BOOT_SIZE_FUSE_I == 2'h0
        |=> RESET_VECTOR_O == 17'h1F000)
        else $error("reset vector wrong");
    a_io_clk_stop: assert property (
        SLEEP_I && !SLEEP_IDLE_I |=> !IO_CLK_RUN_O)
        else $error("io clock ran in deep sleep");
    a_app_lock: assert property (
        (VECTOR_BASE_O != 17'h0 && APP_SIDE_LOCK_BIT_I && !EXEC_IN_BOOT_I)
        [*2] |-> IRQ_BLOCK_O)
        else $error("app lock did not block");
    a_boot_lock: assert property (
        (VECTOR_BASE_O == 17'h0 && BOOT_SIDE_LOCK_BIT_I && EXEC_IN_BOOT_I)
        [*2] |-> IRQ_BLOCK_O)
        else $error("boot lock did not block");
    a_unlock_reads: assert property (
        mcu_wr && WDATA_I[0] ##[1:2] RD_I && ADDR_I == `ADDR_MCU_CONTROL
        |=> RDATA_O[0])
        else $error("unlock bit not readable");
endmodule
bind vector_select_ext_irq vector_select_ext_irq_checker checker_i (.*);

/* File: verif/core_pin_model.sv */
// Core and pin model: retires instructions, pulses interrupt acknowledges, drives pins
`timescale 1ns/1ps
module core_pin_model (
    input wire clk_i,
    output reg instr_done_o,
    output reg [10:0] irq_ack_o,
    output reg [7:0] ded_pins_o,
    output reg [23:0] pc_pins_o,
    output reg exec_in_boot_o
);
    initial begin
        instr_done_o = 1'b0;
        irq_ack_o = 11'h000;
        ded_pins_o = 8'hFF;
        pc_pins_o = 24'h000000;
        exec_in_boot_o = 1'b0;
    end
    task retire;
        @(posedge clk_i) instr_done_o <= 1'b1;
        @(posedge clk_i) instr_done_o <= 1'b0;
    endtask
    task ack(input integer n);
        @(posedge clk_i) irq_ack_o <= 11'h001 << n;
        @(posedge clk_i) irq_ack_o <= 11'h000;
    endtask
    // Software drives its own pins to raise requests
    task drive(input [7:0] d, input [23:0] p);
        @(posedge clk_i) ded_pins_o <= d;
        pc_pins_o <= p;
    endtask
endmodule

/* File: verif/vector_select_ext_irq_tb_top.sv */
// Testbench for vector placement and external interrupt detection
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin \
    failures++; $display("BAD %s exp %0h got %0h", n, e, g); end end
module vector_select_ext_irq_tb_top;
    logic MCLK_I, ARST_N_I, WR_I, RD_I, RESET_TO_BOOT_FUSE_I, SLEEP_I;
    logic APP_SIDE_LOCK_BIT_I, BOOT_SIDE_LOCK_BIT_I, SLEEP_IDLE_I;
    logic STARTUP_DONE_I, EXEC_IN_BOOT_I, INSTR_DONE_I, IRQ_BLOCK_O, WAKE_O;
    logic IO_CLK_RUN_O, PULLUP_DISABLE_O, DEBUG_PORT_DISABLE_O;
    logic [7:0] ADDR_I, WDATA_I, RDATA_O, DED_IRQ_PINS_I;
    logic [23:0] PIN_CHANGE_INPUTS_I;
    logic [1:0] BOOT_SIZE_FUSE_I;
    logic [10:0] IRQ_ACK_I, IRQ_REQ_O;
    logic [16:0] VECTOR_BASE_O, RESET_VECTOR_O, FIRST_VECTOR_O;
    logic [16:0] LAST_VECTOR_O, exp_base;
    int failures = 0, checks_done = 0, cyc = 0, i;
    vector_select_ext_irq vector_select_ext_irq_i (.*);
    core_pin_model core_pin_model_i (.clk_i(MCLK_I),
        .instr_done_o(INSTR_DONE_I), .irq_ack_o(IRQ_ACK_I),
        .ded_pins_o(DED_IRQ_PINS_I), .pc_pins_o(PIN_CHANGE_INPUTS_I),
        .exec_in_boot_o(EXEC_IN_BOOT_I));
    always #20 MCLK_I = ~MCLK_I;
    always @(posedge MCLK_I) begin
        cyc++;
        if (cyc == 4000) begin
            failures++;
            results;
        end
    end
    task results;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task wr(input [7:0] a, input [7:0] d);
        @(posedge MCLK_I) {WR_I, ADDR_I, WDATA_I} <= {1'b1, a, d};
        @(posedge MCLK_I) WR_I <= 1'b0;
        #1;
    endtask
    task rd(input [7:0] a, input [7:0] e);
        @(posedge MCLK_I) {RD_I, ADDR_I} <= {1'b1, a};
        @(posedge MCLK_I) RD_I <= 1'b0;
        #1 `CHK("rdata", e, RDATA_O)
    endtask
    task settle(input integer n);
        repeat (n) @(posedge MCLK_I);
        #1;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        {MCLK_I, ARST_N_I, WR_I, RD_I, ADDR_I, WDATA_I} = 0;
        {BOOT_SIZE_FUSE_I, APP_SIDE_LOCK_BIT_I, BOOT_SIDE_LOCK_BIT_I} = 0;
        {SLEEP_I, SLEEP_IDLE_I, RESET_TO_BOOT_FUSE_I, STARTUP_DONE_I} = 4'h3;
        settle(2);
        ARST_N_I <= 1'b1;
        rd(8'hFF, 8'h00);
        wr(8'h55, 8'h02);
        rd(8'h55, 8'h00);
        `CHK("reset vec", 17'h1F000, RESET_VECTOR_O)
        `CHK("first", 17'h00002, FIRST_VECTOR_O)
        wr(8'h55, 8'h01);
        `CHK("block", 1'b1, IRQ_BLOCK_O)
        wr(8'h55, 8'h02);
        rd(8'h55, 8'h02);
        `CHK("held", 1'b1, IRQ_BLOCK_O)
        core_pin_model_i.retire;
        settle(2);
        `CHK("freed", 1'b0, IRQ_BLOCK_O)
        `CHK("first", 17'h1F002, FIRST_VECTOR_O)
        `CHK("last", 17'h1F070, LAST_VECTOR_O)
        wr(8'h55, 8'h03);
        rd(8'h55, 8'h03);
        settle(3);
        `CHK("timeout", 1'b0, IRQ_BLOCK_O)
        rd(8'h55, 8'h02);
        wr(8'h55, 8'h00);
        rd(8'h55, 8'h02);
        wr(8'h55, 8'h90);
        settle(1);
        `CHK("pud jtd", 2'h3, {PULLUP_DISABLE_O, DEBUG_PORT_DISABLE_O})
        rd(8'h55, 8'h92);
        $display("test vector move done");
        for (i = 0; i < 4; i++) begin
            BOOT_SIZE_FUSE_I <= i[1:0];
            settle(3);
            exp_base = 17'h1F000 | (17'h01000 - (17'h01000 >> i));
            `CHK("base", exp_base, VECTOR_BASE_O)
        end
        BOOT_SIZE_FUSE_I <= 2'h0;
        APP_SIDE_LOCK_BIT_I <= 1'b1;
        settle(3);
        `CHK("app lock", 1'b1, IRQ_BLOCK_O)
        APP_SIDE_LOCK_BIT_I <= 1'b0;
        wr(8'h55, 8'h01);
        wr(8'h55, 8'h00);
        core_pin_model_i.retire;
        settle(2);
        `CHK("base", 17'h00000, VECTOR_BASE_O)
        force_free_boot_lock();
        $display("test locks done");
        wr(8'h3D, 8'h13);
        wr(8'h69, 8'h03);
        wr(8'h6A, 8'h03);
        core_pin_model_i.drive(8'hEE, 24'h0);
        settle(3);
        core_pin_model_i.drive(8'hFF, 24'h0);
        settle(8);
        `CHK("rise", 2'h3, {IRQ_REQ_O[4], IRQ_REQ_O[0]})
        wr(8'h3C, 8'h01);
        core_pin_model_i.ack(4);
        rd(8'h3C, 8'h00);
        core_pin_model_i.drive(8'hFD, 24'h0);
        settle(8);
        wr(8'h3C, 8'h02);
        settle(2);
        `CHK("level", 1'b1, IRQ_REQ_O[1])
        {SLEEP_I, SLEEP_IDLE_I} <= 2'h2;
        core_pin_model_i.drive(8'hEE, 24'h0);
        settle(3);
        core_pin_model_i.drive(8'hFF, 24'h0);
        settle(8);
        `CHK("io clk", 1'b0, IO_CLK_RUN_O)
        `CHK("async", 3'h3, {IRQ_REQ_O[4], IRQ_REQ_O[0], WAKE_O})
        SLEEP_I <= 1'b0;
        wr(8'h3C, 8'hFF);
        $display("test dedicated pins done");
        wr(8'h68, 8'h07);
        for (i = 0; i < 3; i++) begin
            wr(8'h6B + i, 8'h02);
            core_pin_model_i.drive(8'hFF, 24'h000001 << (8 * i));
            settle(8);
            `CHK("masked", 1'b0, IRQ_REQ_O[8 + i])
            core_pin_model_i.drive(8'hFF, 24'h000003 << (8 * i));
            settle(8);
            `CHK("group", 1'b1, IRQ_REQ_O[8 + i])
            core_pin_model_i.ack(8 + i);
        end
        $display("test pin change done");
        results;
    end
    task force_free_boot_lock;
        BOOT_SIDE_LOCK_BIT_I <= 1'b1;
        core_pin_model_i.exec_in_boot_o <= 1'b1;
        settle(3);
        `CHK("boot lock", 1'b1, IRQ_BLOCK_O)
        {BOOT_SIDE_LOCK_BIT_I, core_pin_model_i.exec_in_boot_o} <= 2'h0;
    endtask
endmodule
